// ### common/pocs_pkg.sv
// constants for the on-board analog scaling and output overload block
// assumes a 32-bit apb slave with byte addresses, one word per register
package pocs_pkg;
   // -------------------------------------------------------------
   // register offsets
   // -------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] RANGE_OFS = 8'h04;
   localparam logic [7:0] AIN0_OFS = 8'h08;
   localparam logic [7:0] AOUT0_OFS = 8'h18;
   localparam logic [7:0] AOUT1_OFS = 8'h1c;
   localparam logic [7:0] DOUT_OFS = 8'h20;
   localparam logic [7:0] REEN_OFS = 8'h24;
   localparam logic [7:0] STAT_OFS = 8'h28;
   localparam logic [7:0] ISTAT_OFS = 8'h2c;
   localparam logic [7:0] ICLR_OFS = 8'h30;
   localparam logic [7:0] IEN_OFS = 8'h34;
   // -------------------------------------------------------------
   // widths and field positions
   // -------------------------------------------------------------
   localparam int NUM_AIN = 4;
   localparam int NUM_DOUT = 8;
   localparam int ADC_W = 12;
   localparam int AIN_SHIFT = 3;
   localparam int DAC_W = 12;
   localparam int AOUT_W = 16;
   localparam int RANGE_W = 2;
   localparam int CTRL_AUTO_BIT = 0;
   localparam int CTRL_RUN_BIT = 1;
   localparam int IRQ_BATT_BIT = 8;
   localparam int IRQ_W = 9;
   localparam int STAT_FAULT_POS = 8;
   localparam int STAT_BATT_POS = 16;
   // -------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------
   localparam logic [1:0] CTRL_RST = 2'h1;
   localparam logic [7:0] RANGE_RST = 8'h00;
   localparam logic [15:0] AOUT_RST = 16'h0000;
   localparam logic [7:0] DOUT_RST = 8'h00;
   localparam logic [8:0] IEN_RST = 9'h000;
   localparam logic [15:0] AIN_FULL = 16'h7ff8;
   // -------------------------------------------------------------
   // input signal ranges
   // -------------------------------------------------------------
   typedef enum logic [1:0]
   {
      POCS_RANGE_10V = 2'b00,
      POCS_RANGE_5V = 2'b01,
      POCS_RANGE_20MA = 2'b10
   } pocs_range_type;
endpackage

// ### core/pocs_onboard_io.sv
// on-board i/o: analog input scaling, bipolar analog outputs,
// transistor output overload supervision and battery indicator
// assumes a single 200 mhz clock, apb master, adc/dac on same clock
//
// Operation
// - every analog input channel is converted with twelve bits
// - one converter step moves the program value by exactly 8
// - program input value spans 0 to 7ff8 hex in every range
// - each of four inputs selects 0-10 v, 0-5 v or 0-20 ma
// - each analog output is a twelve bit bipolar converter, -10 to +10 v
// - upper twelve bits of the signed value feed the output converter
// - output values are two's complement; 8000 minus, 7fff plus full scale
// - second analog output behaves exactly like the first
// - second output holds full scale only while the program runs
// - eight transistor outputs are handled as one group
// - an overloaded or shorted output is switched off by hardware
// - one aggregated error shows overload on any output
// - overload lights the indicator and sets program-readable error flags
// - setting picks automatic or program re-enable; automatic after reset
// - indicator goes out once the output is switched on again
// - error flags stay set until explicitly acknowledged
// - battery indicator lights when battery missing or exhausted
`timescale 1ns/100ps
module pocs_onboard_io
(
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_adc_valid,
   input wire logic [1:0] i_adc_chan,
   input wire logic [11:0] i_adc_data,
   output logic [7:0] o_ain_range,
   output logic [11:0] o_dac0,
   output logic [11:0] o_dac1,
   output logic [7:0] o_dout,
   input wire logic [7:0] i_dout_fault,
   output logic o_overload_indicator,
   output logic o_overload_error,
   input wire logic i_battery_bad,
   output logic o_battery_indicator,
   output logic o_irq
);
   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   logic [1:0] ctrl;
   logic [7:0] range_sel;
   logic [15:0] ain [pocs_pkg::NUM_AIN];
   logic [15:0] aout0;
   logic [15:0] aout1;
   logic [7:0] dout_cmd;
   logic [7:0] off;
   logic [7:0] next_off;
   logic [8:0] sync1;
   logic [8:0] sync2;
   logic [8:0] sync3;
   logic [8:0] filt;
   logic [7:0] flt;
   logic bat;
   logic [8:0] istat;
   logic [8:0] ien;
   logic [8:0] ev;
   logic wr;
   logic rd_setup;
   logic [7:0] reen;
   logic [8:0] iclr;
   logic mapped;
   logic [31:0] rdata;

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   // two's complement kept; low four bits dropped, silent when stopped
   function automatic logic [11:0] dac_code(input logic [15:0] v,
                                            input logic run);
      dac_code = run ? v[15:4] : 12'h000;
   endfunction

   // code 11 has no range; it falls back to the widest voltage range
   function automatic logic [1:0] legal_range(input logic [1:0] r);
      legal_range = (r == 2'b11) ? pocs_pkg::POCS_RANGE_10V : r;
   endfunction

   // -------------------------------------------------------------
   // apb slave, zero wait states, read data latched in setup
   // -------------------------------------------------------------
   assign wr = i_psel & i_penable & i_pwrite;
   assign rd_setup = i_psel & ~i_penable;
   assign reen = (wr && i_paddr == pocs_pkg::REEN_OFS) ? i_pwdata[7:0] : 8'h00;
   assign iclr = (wr && i_paddr == pocs_pkg::ICLR_OFS) ? i_pwdata[8:0] : 9'h000;
   assign o_pready = 1'b1;

   always_comb
   begin
      mapped = 1'b1;
      rdata = 32'h0000_0000;
      unique case (i_paddr)
         pocs_pkg::CTRL_OFS: rdata = {30'h0, ctrl};
         pocs_pkg::RANGE_OFS: rdata = {24'h0, range_sel};
         pocs_pkg::AIN0_OFS: rdata = {16'h0, ain[0]};
         pocs_pkg::AIN0_OFS + 8'h04: rdata = {16'h0, ain[1]};
         pocs_pkg::AIN0_OFS + 8'h08: rdata = {16'h0, ain[2]};
         pocs_pkg::AIN0_OFS + 8'h0c: rdata = {16'h0, ain[3]};
         pocs_pkg::AOUT0_OFS: rdata = {16'h0, aout0};
         pocs_pkg::AOUT1_OFS: rdata = {16'h0, aout1};
         pocs_pkg::DOUT_OFS: rdata = {24'h0, dout_cmd};
         pocs_pkg::REEN_OFS: rdata = 32'h0000_0000;
         pocs_pkg::STAT_OFS: rdata = {15'h0, bat, flt, off};
         pocs_pkg::ISTAT_OFS: rdata = {23'h0, istat};
         pocs_pkg::ICLR_OFS: rdata = 32'h0000_0000;
         pocs_pkg::IEN_OFS: rdata = {23'h0, ien};
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
      begin
         o_prdata <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end
      else if (rd_setup)
      begin
         o_prdata <= i_pwrite ? 32'h0000_0000 : rdata;
         o_pslverr <= ~mapped;
      end
   end

   // -------------------------------------------------------------
   // control and configuration registers
   // -------------------------------------------------------------
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
         ctrl <= pocs_pkg::CTRL_RST;
      else if (wr && i_paddr == pocs_pkg::CTRL_OFS)
         ctrl <= i_pwdata[1:0];
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
         range_sel <= pocs_pkg::RANGE_RST;
      else if (wr && i_paddr == pocs_pkg::RANGE_OFS)
         for (int i = 0; i < pocs_pkg::NUM_AIN; i++)
            range_sel[2*i +: 2] <= legal_range(i_pwdata[2*i +: 2]);
   end

   // the range only steers the front end; every range scales the same
   assign o_ain_range = range_sel;

   // -------------------------------------------------------------
   // analog inputs
   // -------------------------------------------------------------
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
      begin
         for (int i = 0; i < pocs_pkg::NUM_AIN; i++)
            ain[i] <= 16'h0000;
      end
      else if (i_adc_valid)
         ain[i_adc_chan] <= {1'b0, i_adc_data, 3'b000};
   end

   // -------------------------------------------------------------
   // analog outputs
   // -------------------------------------------------------------
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
      begin
         aout0 <= pocs_pkg::AOUT_RST;
         aout1 <= pocs_pkg::AOUT_RST;
      end
      else if (wr && i_paddr == pocs_pkg::AOUT0_OFS)
         aout0 <= i_pwdata[15:0];
      else if (wr && i_paddr == pocs_pkg::AOUT1_OFS)
         aout1 <= i_pwdata[15:0];
   end

   // stopping the program drops both channels to zero volts, so no
   // fixed reference survives a stop
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
      begin
         o_dac0 <= 12'h000;
         o_dac1 <= 12'h000;
      end
      else
      begin
         o_dac0 <= dac_code(aout0, ctrl[pocs_pkg::CTRL_RUN_BIT]);
         o_dac1 <= dac_code(aout1, ctrl[pocs_pkg::CTRL_RUN_BIT]);
      end
   end

   // -------------------------------------------------------------
   // pin synchronisers: fault lines and battery monitor
   // -------------------------------------------------------------
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
      begin
         sync1 <= 9'h000;
         sync2 <= 9'h000;
         sync3 <= 9'h000;
      end
      else
      begin
         sync1 <= {i_battery_bad, i_dout_fault};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // a bit moves only when the second and third stage agree
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
         filt <= 9'h000;
      else
         filt <= (filt & (sync2 ^ sync3)) | (sync2 & ~(sync2 ^ sync3));
   end

   assign flt = filt[7:0];
   assign bat = filt[pocs_pkg::IRQ_BATT_BIT];

   // -------------------------------------------------------------
   // transistor output group
   // -------------------------------------------------------------
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
         dout_cmd <= pocs_pkg::DOUT_RST;
      else if (wr && i_paddr == pocs_pkg::DOUT_OFS)
         dout_cmd <= i_pwdata[7:0];
   end

   // an output stays off while its fault persists, even if re-enabled
   always_comb
   begin
      next_off = off | flt;
      for (int i = 0; i < pocs_pkg::NUM_DOUT; i++)
         if (off[i] && !flt[i] && (ctrl[pocs_pkg::CTRL_AUTO_BIT] || reen[i]))
            next_off[i] = 1'b0;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
         off <= 8'h00;
      else
         off <= next_off;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
         o_dout <= 8'h00;
      else
         o_dout <= dout_cmd & ~next_off & ~flt;
   end

   assign o_overload_indicator = |off;

   // -------------------------------------------------------------
   // error flags and interrupt
   // -------------------------------------------------------------
   assign ev = {bat, flt};

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
         istat <= 9'h000;
      else
         istat <= (istat & ~iclr) | ev;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
         ien <= pocs_pkg::IEN_RST;
      else if (wr && i_paddr == pocs_pkg::IEN_OFS)
         ien <= i_pwdata[8:0];
   end

   assign o_overload_error = |istat[7:0];
   assign o_irq = |(istat & ien);

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
         o_battery_indicator <= 1'b0;
      else
         o_battery_indicator <= bat;
   end

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);

   sequence s_fault_seen;
      flt != 8'h00;
   endsequence

   sequence s_off_clearable;
      ctrl[0] && ((off & ~flt) != 8'h00);
   endsequence

   property p_ain_scale;
      i_adc_valid |=> ain[$past(i_adc_chan)] == {1'b0, $past(i_adc_data), 3'b000};
   endproperty
   a_ain_scale: assert property (p_ain_scale) else $error("ain scaling wrong");

   property p_ain_span;
      ain[0] <= pocs_pkg::AIN_FULL && ain[3][2:0] == 3'b000;
   endproperty
   a_ain_span: assert property (p_ain_span) else $error("ain out of span");

   property p_dac_full;
      (ctrl[1] && aout1 == 16'h7fff) ##1 (ctrl[1] && aout1 == 16'h7fff)
         |-> o_dac1 == 12'h7ff;
   endproperty
   a_dac_full: assert property (p_dac_full) else $error("dac full scale wrong");

   property p_dac_neg;
      (aout0 == 16'h800f && ctrl[1]) |=> o_dac0 == 12'h800;
   endproperty
   a_dac_neg: assert property (p_dac_neg) else $error("dac minus scale wrong");

   property p_dac_stop;
      !ctrl[1] |=> o_dac1 == 12'h000 && o_dac0 == 12'h000;
   endproperty
   a_dac_stop: assert property (p_dac_stop) else $error("dac live while stopped");

   property p_fault_off;
      s_fault_seen |=> ((o_dout & $past(flt)) == 8'h00) && o_overload_indicator;
   endproperty
   a_fault_off: assert property (p_fault_off) else $error("faulted output on");

   property p_error;
      s_fault_seen |=> o_overload_error;
   endproperty
   a_error: assert property (p_error) else $error("no aggregated error");

   property p_auto;
      s_off_clearable |=> (off & $past(off & ~flt)) == 8'h00;
   endproperty
   a_auto: assert property (p_auto) else $error("auto re-enable missed");

   property p_manual;
      (!ctrl[0] && reen == 8'h00) |=> (off & $past(off)) == $past(off);
   endproperty
   a_manual: assert property (p_manual) else $error("manual mode re-enabled");

   property p_sticky;
      (iclr == 9'h000) |=> (istat & $past(istat)) == $past(istat);
   endproperty
   a_sticky: assert property (p_sticky) else $error("error flag lost");

   property p_batt;
      bat |=> o_battery_indicator;
   endproperty
   a_batt: assert property (p_batt) else $error("battery indicator dark");
endmodule

// ### bench/pocs_field_model.sv
// field side model: analog converter samples, output load shorts, battery
// assumes the bench calls its tasks; all pins change just after a rising edge
`timescale 1ns/100ps
module pocs_field_model
(
   input wire logic i_clk,
   output logic o_adc_valid,
   output logic [1:0] o_adc_chan,
   output logic [11:0] o_adc_data,
   output logic [7:0] o_fault,
   output logic o_battery_bad
);
   // -------------------------------------------------------------
   // stimulus tasks
   // -------------------------------------------------------------
   initial
   begin
      o_adc_valid = 1'b0;
      o_adc_chan = 2'h0;
      o_adc_data = 12'h5a5;
      o_fault = 8'h00;
      o_battery_bad = 1'b0;
   end
   // one twelve bit sample; data is scrambled after the strobe so stale use shows
   task automatic convert(input logic [1:0] ch, input logic [11:0] code);
      @(posedge i_clk);
      o_adc_valid <= 1'b1;
      o_adc_chan <= ch;
      o_adc_data <= code;
      @(posedge i_clk);
      o_adc_valid <= 1'b0;
      o_adc_chan <= ~ch;
      o_adc_data <= ~code;
   endtask
   // level short per output, held as long as the load is faulty
   task automatic set_short(input logic [7:0] mask);
      @(posedge i_clk);
      o_fault <= mask;
   endtask
   task automatic set_battery(input logic bad);
      @(posedge i_clk);
      o_battery_bad <= bad;
   endtask
endmodule

// ### bench/pocs_onboard_io_tb.sv
// self-checking bench for the on-board i/o block
// assumes zero-wait apb slave and the field model on the far side
`timescale 1ns/100ps
module pocs_onboard_io_tb;
   logic clk = 1'b0;
   logic rstn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready, pslverr, adc_valid, ind, err, batt_ind, irq, batt_bad, slverr;
   logic [1:0] adc_chan;
   logic [11:0] adc_data, dac0, dac1;
   logic [7:0] ain_range, dout, fault;
   logic [31:0] q;
   int miscompares = 0;
   int compares = 0;
   logic [15:0] dac_in [8] = '{16'h8000, 16'h800f, 16'h0000, 16'h000f,
                               16'h7ff0, 16'h7fff, 16'hfff0, 16'h0010};
   logic [11:0] adc_in [4] = '{12'h000, 12'h001, 12'hfff, 12'habc};
   always #2.5 clk = ~clk;
   pocs_onboard_io dut_u (.i_sys_clk(clk), .i_rstn(rstn), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_adc_valid(adc_valid), .i_adc_chan(adc_chan), .i_adc_data(adc_data),
      .o_ain_range(ain_range), .o_dac0(dac0), .o_dac1(dac1), .o_dout(dout),
      .i_dout_fault(fault), .o_overload_indicator(ind), .o_overload_error(err),
      .i_battery_bad(batt_bad), .o_battery_indicator(batt_ind), .o_irq(irq));
   pocs_field_model field_u (.i_clk(clk), .o_adc_valid(adc_valid),
      .o_adc_chan(adc_chan), .o_adc_data(adc_data), .o_fault(fault),
      .o_battery_bad(batt_bad));
   // -------------------------------------------------------------
   // access and compare tasks
   // -------------------------------------------------------------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // request held until pready is seen high; read data taken at that edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // no wait-state count assumed; only the watchdog ends a stuck wait
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      q = prdata;
      slverr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask
   // filter latency is a few cycles; bounded so a dead path cannot hang
   task automatic wait_ind(input logic exp);
      int n;
      for (n = 0; n < 30 && ind !== exp; n++)
         @(posedge clk);
      settle();
   endtask
   // -------------------------------------------------------------
   // tests
   // -------------------------------------------------------------
   initial
   begin
      repeat (20000) @(posedge clk);
      miscompares++;
      print_verdict();
   end
   initial
   begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      apb(1'b0, pocs_pkg::CTRL_OFS, 32'h0);
      check("ctrl reset", q, 32'h1);
      check("pready", {31'h0, pready}, 32'h1);
      apb(1'b0, 8'hfc, 32'h0);
      check("unmapped slverr", {31'h0, slverr}, 32'h1);
      for (int i = 0; i < 4; i++)
      begin
         field_u.convert(2'(i), adc_in[i]);
         apb(1'b0, pocs_pkg::AIN0_OFS + 8'(4 * i), 32'h0);
         check("ain", q, {17'h0, adc_in[i], 3'h0});
      end
      apb(1'b0, pocs_pkg::AIN0_OFS + 8'h08, 32'h0);
      check("ain full", q, {16'h0, pocs_pkg::AIN_FULL});
      apb(1'b1, pocs_pkg::RANGE_OFS, 32'he4);
      settle();
      check("range", {24'h0, ain_range}, 32'h24);
      apb(1'b1, pocs_pkg::CTRL_OFS, 32'h3);
      for (int i = 0; i < 16; i++)
      begin
         apb(1'b1, (i < 8) ? pocs_pkg::AOUT0_OFS : pocs_pkg::AOUT1_OFS, {16'h0, dac_in[i % 8]});
         settle();
         check("dac", {20'h0, (i < 8) ? dac0 : dac1}, {20'h0, dac_in[i % 8][15:4]});
      end
      apb(1'b1, pocs_pkg::AOUT0_OFS, 32'h0010);
      settle();
      check("dac step", {20'h0, dac0}, 32'h1);
      apb(1'b1, pocs_pkg::AOUT1_OFS, 32'h7fff);
      settle();
      check("dac1 run", {20'h0, dac1}, 32'h7ff);
      apb(1'b1, pocs_pkg::CTRL_OFS, 32'h1);
      settle();
      check("dac1 stop", {20'h0, dac1}, 32'h0);
      apb(1'b1, pocs_pkg::DOUT_OFS, 32'hff);
      settle();
      check("dout group", {24'h0, dout}, 32'hff);
      field_u.set_short(8'h04);
      wait_ind(1'b1);
      check("dout off", {24'h0, dout}, 32'hfb);
      check("error", {31'h0, err}, 32'h1);
      check("indicator", {31'h0, ind}, 32'h1);
      apb(1'b0, pocs_pkg::STAT_OFS, 32'h0);
      check("stat", q, 32'h0404);
      field_u.set_short(8'h00);
      wait_ind(1'b0);
      check("dout auto", {24'h0, dout}, 32'hff);
      check("indicator off", {31'h0, ind}, 32'h0);
      check("error kept", {31'h0, err}, 32'h1);
      apb(1'b0, pocs_pkg::ISTAT_OFS, 32'h0);
      check("istat", q, 32'h4);
      apb(1'b1, pocs_pkg::ICLR_OFS, 32'h4);
      settle();
      check("error ack", {31'h0, err}, 32'h0);
      apb(1'b1, pocs_pkg::CTRL_OFS, 32'h0);
      field_u.set_short(8'h20);
      wait_ind(1'b1);
      field_u.set_short(8'h00);
      repeat (12) @(posedge clk);
      #1;
      check("manual held", {24'h0, dout}, 32'hdf);
      check("manual ind", {31'h0, ind}, 32'h1);
      apb(1'b1, pocs_pkg::REEN_OFS, 32'h20);
      settle();
      check("manual on", {24'h0, dout}, 32'hff);
      check("manual ind off", {31'h0, ind}, 32'h0);
      apb(1'b1, pocs_pkg::IEN_OFS, 32'h100);
      field_u.set_battery(1'b1);
      repeat (8) @(posedge clk);
      #1;
      check("battery ind", {31'h0, batt_ind}, 32'h1);
      check("irq on", {31'h0, irq}, 32'h1);
      apb(1'b1, pocs_pkg::IEN_OFS, 32'h0);
      settle();
      check("irq masked", {31'h0, irq}, 32'h0);
      field_u.set_battery(1'b0);
      repeat (8) @(posedge clk);
      apb(1'b1, pocs_pkg::ICLR_OFS, 32'h1ff);
      apb(1'b0, pocs_pkg::ISTAT_OFS, 32'h0);
      check("istat clear", q, 32'h0);
      check("battery ind off", {31'h0, batt_ind}, 32'h0);
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      apb(1'b0, pocs_pkg::CTRL_OFS, 32'h0);
      check("ctrl rerun", q, 32'h1);
      check("dout rerun", {24'h0, dout}, 32'h0);
      print_verdict();
   end
endmodule
